// file: sscr_pkg.sv
// constants for the sync status and calibration register bank
// assumes one 40 MHz clock and an 8-bit register port
package sscr_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_OFFSET_AUTO = 8'h1b;
    localparam logic [7:0] OFS_STATUS = 8'h25;
    localparam logic [7:0] OFS_LPF_HIGH = 8'h26;
    localparam logic [7:0] OFS_LPF_LOW = 8'h27;
    localparam logic [7:0] OFS_TEST_ONE = 8'h28;
    localparam logic [7:0] OFS_TEST_TWO = 8'h29;
    localparam logic [7:0] OFS_TEST_THREE = 8'h2a;
    localparam logic [7:0] OFS_TEST_FOUR = 8'h2b;
    localparam logic [7:0] OFS_OFFSET_HOLD = 8'h2c;
    localparam logic [7:0] OFS_TEST_FIVE = 8'h2d;
    localparam logic [7:0] OFS_TEST_SIX = 8'h2e;
    localparam logic [7:0] OFS_GREEN_FILTER = 8'h34;
    localparam logic [7:0] OFS_GEAR = 8'h36;
    localparam logic [7:0] OFS_GAIN_MATCH = 8'h3c;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_HOLDOVER_POL = 3;
    localparam int BIT_RESTORE_POL = 2;
    localparam int BIT_EXTRANEOUS = 1;
    localparam int BIT_FILTER_LOCK = 0;
    localparam int BIT_OFFSET_AUTO_EN = 5;
    localparam int BIT_OFFSET_HOLD = 4;
    localparam int BIT_GREEN_FILTER_EN = 2;
    localparam int BIT_LOW_GEAR = 0;
    localparam int BIT_GAIN_HOLD = 3;
    localparam logic [2:0] GAIN_MATCH_ON = 3'h6;
    localparam logic [2:0] GAIN_MATCH_OFF = 3'h0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int GREEN_MIN_PULSE_NS = 250;
    localparam int GREEN_MIN_CYC = (GREEN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_WINDOW_NS = 250;
    localparam int SYNC_WINDOW_CYC = (SYNC_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_UPDATES = 10;
    localparam int LOCK_LINES = 8;
    localparam int LPF_W = 12;

    // green-channel sync pulse qualifier states
    typedef enum logic [1:0] {
        SSCR_GF_IDLE = 2'b00,
        SSCR_GF_QUAL = 2'b01,
        SSCR_GF_PASS = 2'b10
    } sscr_gf_state_t;

endpackage

// file: sscr_pol_detect.sv
// polarity detector for one sync-like input
// assumes sig_in is synchronous to sys_clk
module sscr_pol_detect #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // signal
    input wire logic sig_in,
    output logic pol_positive
);
    localparam logic [CNT_W-1:0] MID = {1'b1, {(CNT_W-1){1'b0}}};
    localparam logic [CNT_W-1:0] TOP = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    logic [CNT_W-1:0] balance;

    if (CNT_W < 2) begin : g_chk
        $error("sscr_pol_detect: CNT_W must be at least 2");
    end

    // low time counts up, high time down; mostly low means short high pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            balance <= MID;
        end else if (ce) begin
            if (!sig_in && balance != TOP) begin
                balance <= balance + ONE;
            end else if (sig_in && balance != '0) begin
                balance <= balance - ONE;
            end
        end
    end

    // registered polarity decision
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pol_positive <= 1'b0;
        end else if (ce) begin
            pol_positive <= (balance >= MID);
        end
    end
endmodule

// file: sscr_regs.sv
// status and calibration register bank of the capture front end
// assumes inputs synchronous to sys_clk, sync inputs normalised active high
//
// Chosen here: strobed register access.
module sscr_regs #(
    parameter int CORR_W = 10,
    parameter int POL_CNT_W = 8,
    parameter int PERIOD_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // sync inputs
    input wire logic pll_holdover_input,
    input wire logic black_level_restore_input,
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic green_channel_sync,
    // calibration
    input wire logic update_tick,
    input wire logic [CORR_W-1:0] offset_target,
    input wire logic [CORR_W-1:0] gain_target,
    output logic [CORR_W-1:0] offset_corr,
    output logic [CORR_W-1:0] gain_corr,
    output logic offset_settled,
    output logic gain_settled,
    // pll side
    output logic pll_green_sync,
    output logic vco_low_gear
);
    import sscr_pkg::*;
    localparam logic [PERIOD_W-1:0] WIN = PERIOD_W'(SYNC_WINDOW_CYC);
    localparam logic [3:0] GF_MIN = 4'(GREEN_MIN_CYC - 1);
    localparam logic [3:0] SETTLE_N = 4'(SETTLE_UPDATES);
    localparam logic [3:0] LOCK_N = 4'(LOCK_LINES);
    localparam logic [LPF_W-1:0] LPF_MAX = {LPF_W{1'b1}};
    if (CORR_W < 1 || CORR_W > 16 || PERIOD_W < 8 || GREEN_MIN_CYC > 16) begin : g_chk
        $error("sscr_regs: parameter out of range");
    end
    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] test_one;
    logic [7:0] test_two;
    logic [7:0] test_five;
    logic [7:0] test_six;
    logic [7:0] offset_hold_control;
    logic [7:0] offset_auto_control;
    logic [7:0] green_sync_filter_control;
    logic [7:0] oscillator_gear_control;
    logic [7:0] gain_matching_control;
    // software writes; reserved control bits are stored as written
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            test_one <= RST_TEST;
            test_two <= RST_TEST;
            test_five <= RST_TEST;
            test_six <= RST_TEST;
            offset_hold_control <= RST_CONTROL;
            offset_auto_control <= RST_CONTROL;
            green_sync_filter_control <= RST_CONTROL;
            oscillator_gear_control <= RST_CONTROL;
            gain_matching_control <= RST_CONTROL;
        end else if (ce && wr) begin
            case (addr)
                OFS_TEST_ONE: test_one <= wdata;
                OFS_TEST_TWO: test_two <= wdata;
                OFS_TEST_FIVE: test_five <= wdata;
                OFS_TEST_SIX: test_six <= wdata;
                OFS_OFFSET_HOLD: offset_hold_control <= wdata;
                OFS_OFFSET_AUTO: offset_auto_control <= wdata;
                OFS_GREEN_FILTER: green_sync_filter_control <= wdata;
                OFS_GEAR: oscillator_gear_control <= wdata;
                OFS_GAIN_MATCH: gain_matching_control <= wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // polarity of holdover and restore inputs
    // ****************************************
    logic holdover_pol;
    logic restore_pol;
    sscr_pol_detect #(
        .CNT_W(POL_CNT_W)
    ) u_holdover_pol (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .sig_in(pll_holdover_input),
        .pol_positive(holdover_pol)
    );
    sscr_pol_detect #(
        .CNT_W(POL_CNT_W)
    ) u_restore_pol (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .sig_in(black_level_restore_input),
        .pol_positive(restore_pol)
    );
    // ****************************************
    // horizontal sync filter
    // ****************************************
    logic hsync_d;
    logic vsync_d;
    logic [PERIOD_W-1:0] line_timer;
    logic [PERIOD_W-1:0] last_period;
    logic line_dirty;
    logic extraneous;
    logic [3:0] clean_lines;
    logic filter_lock;
    logic hs_edge;
    logic vs_edge;
    logic line_start;
    logic period_match;
    assign hs_edge = hsync_in && !hsync_d;
    assign vs_edge = vsync_in && !vsync_d;
    // an edge inside the window after the last accepted start is not a line
    assign line_start = hs_edge && (line_timer >= WIN);
    assign period_match = (line_timer + WIN >= last_period) && (line_timer <= last_period + WIN);
    // edge history of the sync inputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hsync_d <= 1'b0;
            vsync_d <= 1'b0;
        end else if (ce) begin
            hsync_d <= hsync_in;
            vsync_d <= vsync_in;
        end
    end
    // time since last accepted line start, saturating
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_timer <= '1;
            last_period <= '0;
        end else if (ce) begin
            if (line_start) begin
                line_timer <= PERIOD_W'(1);
                last_period <= line_timer;
            end else if (line_timer != '1) begin
                line_timer <= line_timer + PERIOD_W'(1);
            end
        end
    end
    // extra edges during active sync mark the line; flag follows the last line
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_dirty <= 1'b0;
            extraneous <= 1'b0;
        end else if (ce) begin
            if (line_start) begin
                extraneous <= line_dirty;
                line_dirty <= 1'b0;
            end else if (hs_edge) begin
                line_dirty <= 1'b1;
            end
        end
    end
    // lock after a run of lines with steady period
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clean_lines <= 4'h0;
            filter_lock <= 1'b0;
        end else if (ce) begin
            if (line_start) begin
                if (!period_match) begin
                    clean_lines <= 4'h0;
                    filter_lock <= 1'b0;
                end else if (clean_lines != LOCK_N) begin
                    clean_lines <= clean_lines + 4'h1;
                end else begin
                    filter_lock <= 1'b1;
                end
            end else if (line_timer == '1) begin
                clean_lines <= 4'h0;
                filter_lock <= 1'b0;
            end
        end
    end

    // ****************************************
    // lines per frame counter
    // ****************************************
    logic [LPF_W-1:0] line_count;
    logic [LPF_W-1:0] lines_per_frame;
    // count accepted line starts, latch at each frame start
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_count <= '0;
            lines_per_frame <= '0;
        end else if (ce) begin
            if (vs_edge) begin
                lines_per_frame <= line_count;
                line_count <= line_start ? LPF_W'(1) : '0;
            end else if (line_start && line_count != LPF_MAX) begin
                line_count <= line_count + LPF_W'(1);
            end
        end
    end

    // ****************************************
    // green-channel sync pulse filter
    // ****************************************
    sscr_gf_state_t gf_state;
    sscr_gf_state_t next_gf_state;
    logic [3:0] gf_cnt;
    logic gf_enable;
    assign gf_enable = green_sync_filter_control[BIT_GREEN_FILTER_EN];
    // qualify pulse width before passing it on
    always_comb begin
        next_gf_state = gf_state;
        case (gf_state)
            SSCR_GF_IDLE: begin
                if (green_channel_sync) begin
                    next_gf_state = gf_enable ? SSCR_GF_QUAL : SSCR_GF_PASS;
                end
            end
            SSCR_GF_QUAL: begin
                if (!green_channel_sync) begin
                    next_gf_state = SSCR_GF_IDLE;
                end else if (gf_cnt == GF_MIN) begin
                    next_gf_state = SSCR_GF_PASS;
                end
            end
            SSCR_GF_PASS: begin
                if (!green_channel_sync) begin
                    next_gf_state = SSCR_GF_IDLE;
                end
            end
            default: next_gf_state = SSCR_GF_IDLE;
        endcase
    end
    // state and width counter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gf_state <= SSCR_GF_IDLE;
            gf_cnt <= 4'h0;
        end else if (ce) begin
            gf_state <= next_gf_state;
            if (gf_state == SSCR_GF_QUAL) begin
                gf_cnt <= gf_cnt + 4'h1;
            end else begin
                gf_cnt <= 4'h1;
            end
        end
    end
    // pulse to pll; with filter on it starts after the minimum width has passed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pll_green_sync <= 1'b0;
        end else if (ce) begin
            pll_green_sync <= (next_gf_state == SSCR_GF_PASS);
        end
    end
    // oscillator gear select
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            vco_low_gear <= 1'b0;
        end else if (ce) begin
            vco_low_gear <= oscillator_gear_control[BIT_LOW_GEAR];
        end
    end

    // ****************************************
    // offset and gain correction trackers
    // ****************************************
    logic offset_run;
    logic gain_run;
    logic [3:0] offset_updates;
    logic [3:0] gain_updates;
    assign offset_run = offset_auto_control[BIT_OFFSET_AUTO_EN]
        && !offset_hold_control[BIT_OFFSET_HOLD];
    assign gain_run = (gain_matching_control[2:0] == GAIN_MATCH_ON)
        && gain_matching_control[BIT_GAIN_HOLD];
    // offset follows its target on each update while running, frozen otherwise
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            offset_corr <= '0;
            offset_updates <= 4'h0;
        end else if (ce) begin
            if (!offset_run) begin
                offset_updates <= 4'h0;
            end else if (update_tick) begin
                offset_corr <= offset_target;
                if (offset_updates != SETTLE_N) begin
                    offset_updates <= offset_updates + 4'h1;
                end
            end
        end
    end
    // gain follows its target on each update while enabled and the hold bit is set
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gain_corr <= '0;
            gain_updates <= 4'h0;
        end else if (ce) begin
            if (!gain_run) begin
                gain_updates <= 4'h0;
            end else if (update_tick) begin
                gain_corr <= gain_target;
                if (gain_updates != SETTLE_N) begin
                    gain_updates <= gain_updates + 4'h1;
                end
            end
        end
    end
    // settled once ten updates have run
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            offset_settled <= 1'b0;
            gain_settled <= 1'b0;
        end else if (ce) begin
            offset_settled <= (offset_updates == SETTLE_N);
            gain_settled <= (gain_updates == SETTLE_N);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] status_byte;
    logic [7:0] next_rdata;
    always_comb begin
        status_byte = 8'h00;
        status_byte[BIT_HOLDOVER_POL] = holdover_pol;
        status_byte[BIT_RESTORE_POL] = restore_pol;
        status_byte[BIT_EXTRANEOUS] = extraneous;
        status_byte[BIT_FILTER_LOCK] = filter_lock;
    end
    // read mux; status and count come from live state only
    always_comb begin
        case (addr)
            OFS_STATUS: next_rdata = status_byte;
            OFS_LPF_HIGH: next_rdata = lines_per_frame[11:4];
            OFS_LPF_LOW: next_rdata = {lines_per_frame[3:0], 4'h0};
            OFS_TEST_ONE: next_rdata = test_one;
            OFS_TEST_TWO: next_rdata = test_two;
            OFS_TEST_THREE: next_rdata = 8'h00;
            OFS_TEST_FOUR: next_rdata = 8'h00;
            OFS_OFFSET_HOLD: next_rdata = offset_hold_control;
            OFS_OFFSET_AUTO: next_rdata = offset_auto_control;
            OFS_TEST_FIVE: next_rdata = test_five;
            OFS_TEST_SIX: next_rdata = test_six;
            OFS_GREEN_FILTER: next_rdata = green_sync_filter_control;
            OFS_GEAR: next_rdata = oscillator_gear_control;
            OFS_GAIN_MATCH: next_rdata = gain_matching_control;
            default: next_rdata = RD_UNMAPPED;
        endcase
    end
    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? next_rdata : 8'h00;
        end
    end
endmodule

// file: sscr_regs_checker.sv
// assertions for the sync status and calibration register bank
// assumes binding to sscr_regs, one clock, ports as declared there
module sscr_checker
    import sscr_pkg::*;
#(
    parameter int CORR_W = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // sync and calibration
    input wire logic green_channel_sync,
    input wire logic update_tick,
    input wire logic [CORR_W-1:0] offset_target,
    input wire logic [CORR_W-1:0] gain_target,
    input wire logic [CORR_W-1:0] offset_corr,
    input wire logic [CORR_W-1:0] gain_corr,
    input wire logic offset_settled,
    input wire logic gain_settled,
    input wire logic pll_green_sync,
    input wire logic vco_low_gear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic off_en, off_hold, filt_en, gain_run, off_run;
    logic [3:0] gain_ctl, gcnt, ocnt, hi_cnt;
    // ****************************************
    // helper logic
    // ****************************************
    // run conditions from the shadowed control bits
    assign gain_run = gain_ctl[2:0] == GAIN_MATCH_ON && gain_ctl[3];
    assign off_run = off_en && !off_hold;
    // shadow copies of the control bits written by software
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            off_en <= 1'b0;
            off_hold <= 1'b0;
            filt_en <= 1'b0;
            gain_ctl <= 4'h0;
        end else if (ce && wr) begin
            if (addr == OFS_OFFSET_AUTO) off_en <= wdata[BIT_OFFSET_AUTO_EN];
            if (addr == OFS_OFFSET_HOLD) off_hold <= wdata[BIT_OFFSET_HOLD];
            if (addr == OFS_GREEN_FILTER) filt_en <= wdata[BIT_GREEN_FILTER_EN];
            if (addr == OFS_GAIN_MATCH) gain_ctl <= wdata[3:0];
        end
    end
    // tick counts while running and width of the current green pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gcnt <= 4'h0;
            ocnt <= 4'h0;
            hi_cnt <= 4'h0;
        end else if (ce) begin
            gcnt <= gain_run ? gcnt + 4'(update_tick && gcnt != 4'hf) : 4'h0;
            ocnt <= off_run ? ocnt + 4'(update_tick && ocnt != 4'hf) : 4'h0;
            hi_cnt <= green_channel_sync ? hi_cnt + 4'(hi_cnt != 4'hf) : 4'h0;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_gear_wr;
        ce && wr && addr == OFS_GEAR ##1 ce;
    endsequence
    sequence s_gain_last;
        ce && gain_run && update_tick && gcnt == 4'd9;
    endsequence
    sequence s_off_last;
        ce && off_run && update_tick && ocnt == 4'd9;
    endsequence
    property p_reserved_zero;
        ce && rd && (addr == OFS_TEST_THREE || addr == OFS_TEST_FOUR) |=> rdata == 8'h00;
    endproperty
    property p_gear;
        s_gear_wr |=> vco_low_gear == $past(wdata[BIT_LOW_GEAR], 2);
    endproperty
    property p_green_width;
        filt_en && $rose(pll_green_sync) |-> $past(hi_cnt) >= 4'd9;
    endproperty
    property p_gain_copy;
        ce && gain_run && update_tick |=> gain_corr == $past(gain_target);
    endproperty
    property p_gain_hold;
        ce && !gain_run |=> $stable(gain_corr);
    endproperty
    property p_off_copy;
        ce && off_run && update_tick |=> offset_corr == $past(offset_target);
    endproperty
    property p_off_hold;
        ce && !off_run |=> $stable(offset_corr);
    endproperty
    property p_gain_settle;
        s_gain_last |-> ##[1:2] gain_settled;
    endproperty
    property p_off_settle;
        s_off_last |-> ##[1:2] offset_settled;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved register read not zero");
    a_gear: assert property (p_gear)
        else $error("gear output differs from written bit");
    a_green_width: assert property (p_green_width)
        else $error("short green sync pulse passed");
    a_gain_copy: assert property (p_gain_copy)
        else $error("gain not updated while running");
    a_gain_hold: assert property (p_gain_hold)
        else $error("gain changed while held");
    a_off_copy: assert property (p_off_copy)
        else $error("offset not updated while running");
    a_off_hold: assert property (p_off_hold)
        else $error("offset changed while held");
    a_gain_settle: assert property (p_gain_settle)
        else $error("gain not settled after ten updates");
    a_off_settle: assert property (p_off_settle)
        else $error("offset not settled after ten updates");
endmodule

// file: tb_sscr_regs.sv
// self-checking bench for the sync status and calibration register bank
// assumes sscr_pkg, sscr_regs and sscr_checker compiled before it
module tb_sscr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import sscr_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic pll_holdover_input = 1'b0, black_level_restore_input = 1'b0, hsync_in = 1'b0, vsync_in = 1'b0;
    logic green_channel_sync = 1'b0, update_tick = 1'b0, offset_settled, gain_settled, pll_green_sync, vco_low_gear;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [9:0] offset_target = 10'h000, gain_target = 10'h000, offset_corr, gain_corr;
    logic [7:0] ra [7] = '{OFS_TEST_ONE, OFS_TEST_TWO, OFS_TEST_FIVE, OFS_TEST_SIX, OFS_TEST_THREE, OFS_TEST_FOUR, 8'h40};
    logic [7:0] wv [7] = '{8'hbf, 8'h02, 8'he8, 8'he0, 8'hff, 8'hff, 8'hff};
    logic [7:0] ev [7] = '{8'hbf, 8'h02, 8'he8, 8'he0, 8'h00, 8'h00, 8'h00};
    logic [7:0] cr [5] = '{OFS_OFFSET_AUTO, OFS_OFFSET_HOLD, OFS_GREEN_FILTER, OFS_GEAR, OFS_GAIN_MATCH};
    int fails = 0, samples_checked = 0;
    sscr_regs dut_u (.sys_clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata, .pll_holdover_input,
        .black_level_restore_input, .hsync_in, .vsync_in, .green_channel_sync, .update_tick, .offset_target,
        .gain_target, .offset_corr, .gain_corr, .offset_settled, .gain_settled, .pll_green_sync, .vco_low_gear);
    // free-running clock
    always #12.5 sys_clk = ~sys_clk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 check({8'h00, rdata & m}, {8'h00, e});
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            update_tick <= 1'b1;
            @(posedge sys_clk);
            update_tick <= 1'b0;
        end
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic gpulse(input int n, input logic e);
        logic hit;
        hit = 1'b0;
        @(posedge sys_clk);
        green_channel_sync <= 1'b1;
        for (int c = 0; c < n + 14; c++) begin
            @(posedge sys_clk);
            if (c == n - 1) green_channel_sync <= 1'b0;
            #1 if (pll_green_sync === 1'b1) hit = 1'b1;
        end
        check({15'h0, hit}, {15'h0, e});
    endtask
    task automatic test_done();
        $display("checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************
    // sequence of tests
    // ****************************************
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (cr[k]) chk_rd(cr[k], 8'hff, 8'h00);
        foreach (ra[k]) chk_rd(ra[k], 8'hff, 8'h00);
        foreach (ra[k]) wr_reg(ra[k], wv[k]);
        foreach (ra[k]) chk_rd(ra[k], 8'hff, ev[k]);
        $display("register table done");
        fork
            for (int i = 0; i < 500; i++) begin
                @(posedge sys_clk);
                pll_holdover_input <= (i % 20 == 3);
                black_level_restore_input <= (i % 20 != 3);
                hsync_in <= (i % 20 < 2) || (i >= 400 && i % 20 == 5);
                vsync_in <= (i == 10 || i == 270);
            end
            begin
                repeat (390) @(posedge sys_clk);
                chk_rd(OFS_STATUS, 8'h0f, 8'h09);
            end
        join
        for (int k = 0; k < 3; k++) wr_reg(OFS_STATUS + 8'(k), 8'hff);
        chk_rd(OFS_STATUS, 8'h0f, 8'h0b);
        chk_rd(OFS_LPF_HIGH, 8'hff, 8'h00);
        chk_rd(OFS_LPF_LOW, 8'hff, 8'hd0);
        $display("status done");
        wr_reg(OFS_GREEN_FILTER, 8'h04);
        gpulse(9, 1'b0);
        gpulse(11, 1'b1);
        wr_reg(OFS_GREEN_FILTER, 8'h00);
        gpulse(3, 1'b1);
        wr_reg(OFS_GEAR, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 check({15'h0, vco_low_gear}, 16'h0001);
        wr_reg(OFS_GEAR, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1 check({15'h0, vco_low_gear}, 16'h0000);
        $display("filter and gear done");
        @(posedge sys_clk);
        offset_target <= 10'h155;
        gain_target <= 10'h2aa;
        wr_reg(OFS_OFFSET_AUTO, 8'h20);
        wr_reg(OFS_GAIN_MATCH, 8'h0e);
        ticks(9);
        check({14'h0, offset_settled, gain_settled}, 16'h0000);
        ticks(1);
        check({14'h0, offset_settled, gain_settled}, 16'h0003);
        check({6'h0, offset_corr}, 16'h0155);
        check({6'h0, gain_corr}, 16'h02aa);
        wr_reg(OFS_OFFSET_HOLD, 8'h10);
        wr_reg(OFS_GAIN_MATCH, 8'h06);
        @(posedge sys_clk);
        offset_target <= 10'h0aa;
        gain_target <= 10'h111;
        ticks(3);
        check({6'h0, offset_corr}, 16'h0155);
        check({6'h0, gain_corr}, 16'h02aa);
        wr_reg(OFS_GAIN_MATCH, 8'h08);
        ticks(2);
        check({6'h0, gain_corr}, 16'h02aa);
        $display("calibration done");
        test_done();
    end
endmodule
bind sscr_regs sscr_checker #(.CORR_W(CORR_W)) chk_u (.sys_clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .green_channel_sync, .update_tick, .offset_target, .gain_target, .offset_corr, .gain_corr, .offset_settled,
    .gain_settled, .pll_green_sync, .vco_low_gear);
